// file: core/bfbt_top.sv
// Breaker failure supervision with backup and repeat trip outputs.
// Assumes current magnitudes come from logic on CLOCK; pins are async.
//
// Functional notes
// - Timer launches on start rising edge
// - Supervise current, contact or both while running
// - Current mode ignores breaker status
// - Contact mode ignores current thresholds
// - Combined mode resets only when both healthy
// - Expiry with fault still present trips backup
// - Trip lasts at least pulse length
// - Optional repeat trip to primary breaker
// - Off mode never trips
// - Block input inhibits all trips
// - Current criterion clears within reset time
// - Four modes, off after reset
// - Backup delay 60 to 1000 ms
// - Pulse length 0 to 60000 ms
`timescale 1ns/10ps
`default_nettype none
module bfbt_top
#(
   parameter int CYC_PER_MS = bfbt_pkg::MS_CYCLES   // Cycles per ms
)
(
   input  wire logic        CLOCK,
   input  wire logic        RESETN,
   input  wire logic        HSEL,
   input  wire logic [31:0] HADDR,
   input  wire logic [1:0]  HTRANS,
   input  wire logic        HWRITE,
   input  wire logic [2:0]  HSIZE,
   input  wire logic [31:0] HWDATA,
   input  wire logic        HREADY,
   output logic             HREADYOUT,
   output logic             HRESP,
   output logic [31:0]      HRDATA,
   input  wire logic        GENERAL_START_IN,
   input  wire logic        CB_CLOSED,
   input  wire logic        BLOCK,
   input  wire logic [15:0] I_PH_A,
   input  wire logic [15:0] I_PH_B,
   input  wire logic [15:0] I_PH_C,
   input  wire logic [15:0] I_RES,
   output logic             BACKUP_TRIP,
   output logic             REPEAT_TRIP,
   output logic             IRQ
);
   import bfbt_pkg::*;

   // ----------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------
   typedef enum logic {ST_IDLE, ST_RUN} bfbt_state_t;
   bfbt_state_t state, next_state;         // Supervision state
   bfbt_mode_t  supervision_mode_sel;      // Mode field
   logic             rep_en;               // Repeat trip enable
   logic [9:0]       backup_delay_ms;      // Backup delay
   logic [15:0]      trip_pulse_min_ms;    // Pulse length
   logic [15:0]      phase_current_threshold;
   logic [15:0]      residual_current_threshold;
   logic [EV_W-1:0]  sts, msk;             // Sticky status, mask
   bfbt_mode_t       next_mode;
   logic             next_rep;
   logic [9:0]       next_delay;
   logic [15:0]      next_pulse, next_ph, next_res;
   logic [EV_W-1:0]  next_sts, next_msk;
   logic [9:0]       tmr, next_tmr;        // Backup timer, ms
   logic [31:0]      pre, next_pre;        // Millisecond prescaler
   logic             tick;                 // One-ms strobe
   logic [2:0]       gs_s, cb_s, bk_s;     // Sync chains plus edge flop
   logic             cur_flt;              // Current criterion
   logic             launch, inhibit, flt, fire, healthy;
   logic             wr_pend;              // Write data phase due
   logic [7:0]       wr_addr;              // Its address
   logic [31:0]      rd_val;               // Read mux
   logic             irq_q;
   logic             addr_ok;

   bfbt_pulse_if bk_if ();                 // Backup trip pulse
   bfbt_pulse_if rp_if ();                 // Repeat trip pulse

   // Fault per mode; the unused criterion is ignored
   function automatic logic mode_fault(bfbt_mode_t m, logic c, logic b);
      case (m)
         MODE_CUR:  mode_fault = c;
         MODE_CON:  mode_fault = b;
         MODE_BOTH: mode_fault = c | b;
         default:   mode_fault = 1'b0;
      endcase
   endfunction : mode_fault

   // ----------------------------------------------------------
   // Pin synchronisers and current criterion
   // ----------------------------------------------------------
   // Two flops per pin, third flop of start for edge detect
   always_ff @(posedge CLOCK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         gs_s    <= 3'h0;
         cb_s    <= 3'h0;
         bk_s    <= 3'h0;
         cur_flt <= 1'b0;
      end
      else
      begin
         gs_s <= {gs_s[1:0], GENERAL_START_IN};
         cb_s <= {cb_s[1:0], CB_CLOSED};
         bk_s <= {bk_s[1:0], BLOCK};
         // Compared every cycle, so it clears well inside the reset time
         cur_flt <= (I_PH_A > phase_current_threshold)
                  | (I_PH_B > phase_current_threshold)
                  | (I_PH_C > phase_current_threshold)
                  | (I_RES  > residual_current_threshold);
      end
   end

   assign launch  = gs_s[1] & ~gs_s[2];
   assign inhibit = (supervision_mode_sel == MODE_OFF) | bk_s[1];
   assign flt     = mode_fault(supervision_mode_sel, cur_flt, cb_s[1]);

   // ----------------------------------------------------------
   // Millisecond prescaler
   // ----------------------------------------------------------
   always_comb
   begin
      tick     = (pre == 32'(CYC_PER_MS - 1));
      next_pre = tick ? 32'h00000000 : pre + 32'h00000001;
   end

   // ----------------------------------------------------------
   // Supervision sequencer
   // ----------------------------------------------------------
   // Next state and timer
   always_comb
   begin
      next_state = state;
      next_tmr   = tmr;
      fire       = 1'b0;
      healthy    = 1'b0;
      if (inhibit)
      begin
         next_state = ST_IDLE;     // Stale timer dropped
         next_tmr   = 10'h000;
      end
      else if (launch)
      begin
         next_state = ST_RUN;      // Every edge restarts
         next_tmr   = backup_delay_ms;
      end
      else if (state == ST_RUN)
      begin
         if (!flt)
         begin
            next_state = ST_IDLE;  // Healthy per mode
            healthy    = 1'b1;
         end
         else if (tick)
         begin
            if (tmr == 10'h000)
            begin
               next_state = ST_IDLE;
               fire       = 1'b1;  // Expired, still faulted
            end
            else
               next_tmr = tmr - 10'h001;
         end
      end
   end

   // Register sequencer and prescaler
   always_ff @(posedge CLOCK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         state <= ST_IDLE;
         tmr   <= 10'h000;
         pre   <= 32'h00000000;
      end
      else
      begin
         state <= next_state;
         tmr   <= next_tmr;
         pre   <= next_pre;
      end
   end

   // ----------------------------------------------------------
   // Trip pulses
   // ----------------------------------------------------------
   assign bk_if.load = fire;
   assign bk_if.kill = inhibit;
   assign bk_if.hold = flt;
   assign bk_if.tick = tick;
   assign bk_if.len  = trip_pulse_min_ms;
   assign rp_if.load = launch & ~inhibit & rep_en;
   assign rp_if.kill = inhibit;
   assign rp_if.hold = 1'b0;
   assign rp_if.tick = tick;
   assign rp_if.len  = trip_pulse_min_ms;

   bfbt_pulse u_bk (.CLOCK(CLOCK), .RESETN(RESETN), .p(bk_if.pulse));
   bfbt_pulse u_rp (.CLOCK(CLOCK), .RESETN(RESETN), .p(rp_if.pulse));
   assign BACKUP_TRIP = bk_if.active;
   assign REPEAT_TRIP = rp_if.active;

   // ----------------------------------------------------------
   // AHB-Lite register slave
   // ----------------------------------------------------------
   assign addr_ok = (HADDR[31:8] == 24'h000000) && (HADDR[1:0] == 2'h0);

   // Read mux, sampled in the address phase
   always_comb
   begin
      rd_val = 32'h00000000;
      if (addr_ok)
      begin
         case (HADDR[7:0])
            OFS_CTRL:    rd_val = {29'h0, rep_en, supervision_mode_sel};
            OFS_DELAY:   rd_val = {22'h0, backup_delay_ms};
            OFS_PULSE:   rd_val = {16'h0, trip_pulse_min_ms};
            OFS_PH_THR:  rd_val = {16'h0, phase_current_threshold};
            OFS_RES_THR: rd_val = {16'h0, residual_current_threshold};
            OFS_STATUS:  rd_val = {28'h0, sts};
            OFS_MASK:    rd_val = {28'h0, msk};
            OFS_STATE:   rd_val = {26'h0, bk_s[1], cb_s[1], cur_flt,
                                   REPEAT_TRIP, BACKUP_TRIP, state == ST_RUN};
            default:     rd_val = 32'h00000000;
         endcase
      end
   end

   // Register writes in the data phase; set beats clear on status
   always_comb
   begin
      next_mode  = supervision_mode_sel;
      next_rep   = rep_en;
      next_delay = backup_delay_ms;
      next_pulse = trip_pulse_min_ms;
      next_ph    = phase_current_threshold;
      next_res   = residual_current_threshold;
      next_msk   = msk;
      next_sts   = sts;
      if (wr_pend)
      begin
         case (wr_addr)
            OFS_CTRL:
            begin
               next_mode = bfbt_mode_t'(HWDATA[1:0]);
               next_rep  = HWDATA[CTRL_REP_BIT];
            end
            OFS_DELAY:   next_delay = HWDATA[9:0];
            OFS_PULSE:   next_pulse = HWDATA[15:0];
            OFS_PH_THR:  next_ph    = HWDATA[15:0];
            OFS_RES_THR: next_res   = HWDATA[15:0];
            OFS_STATUS:  next_sts   = sts & ~HWDATA[EV_W-1:0];
            OFS_MASK:    next_msk   = HWDATA[EV_W-1:0];
            default:     next_msk   = msk;
         endcase
      end
      next_sts[EV_BACKUP]  = next_sts[EV_BACKUP]  | fire;
      next_sts[EV_REPEAT]  = next_sts[EV_REPEAT]  | rp_if.load;
      next_sts[EV_START]   = next_sts[EV_START]   | (launch & ~inhibit);
      next_sts[EV_HEALTHY] = next_sts[EV_HEALTHY] | healthy;
   end

   // Register file, bus outputs and interrupt
   always_ff @(posedge CLOCK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         supervision_mode_sel       <= MODE_OFF;
         rep_en                     <= 1'b0;
         backup_delay_ms            <= RST_DELAY;
         trip_pulse_min_ms          <= RST_PULSE;
         phase_current_threshold    <= RST_PH_THR;
         residual_current_threshold <= RST_RES_THR;
         sts                        <= '0;
         msk                        <= '0;
         wr_pend                    <= 1'b0;
         wr_addr                    <= 8'h00;
         HRDATA                     <= 32'h00000000;
         HREADYOUT                  <= 1'b1;
         HRESP                      <= 1'b0;
         irq_q                      <= 1'b0;
      end
      else
      begin
         supervision_mode_sel       <= next_mode;
         rep_en                     <= next_rep;
         backup_delay_ms            <= next_delay;
         trip_pulse_min_ms          <= next_pulse;
         phase_current_threshold    <= next_ph;
         residual_current_threshold <= next_res;
         sts                        <= next_sts;
         msk                        <= next_msk;
         wr_pend    <= HSEL & HTRANS[1] & HREADY & HWRITE & addr_ok;
         wr_addr    <= HADDR[7:0];
         HRDATA     <= rd_val;
         HREADYOUT  <= 1'b1;     // Zero wait states
         HRESP      <= 1'b0;     // Always OKAY
         irq_q      <= |(sts & msk);
      end
   end

   assign IRQ = irq_q;

   // ----------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------
   default clocking cb_clk @(posedge CLOCK); endclocking
   default disable iff (!RESETN);

   logic [31:0] on_cyc;   // Cycles the backup trip has been high
   always_ff @(posedge CLOCK or negedge RESETN)
   begin
      if (!RESETN)
         on_cyc <= 32'h00000000;
      else
         on_cyc <= BACKUP_TRIP ? on_cyc + 32'h00000001 : 32'h00000000;
   end

   sequence s_launch;
      launch && !inhibit;
   endsequence
   sequence s_run_quiet;
      state == ST_RUN && !launch && !inhibit && !tick;
   endsequence

   a_launch_run: assert property (s_launch |=> state == ST_RUN && tmr == backup_delay_ms)
      else $error("launch did not load the backup timer");
   a_cur_ignore: assert property (s_run_quiet and supervision_mode_sel == MODE_CUR
      && !cur_flt |=> state == ST_IDLE)
      else $error("current mode did not reset on low current");
   a_con_ignore: assert property (s_run_quiet and supervision_mode_sel == MODE_CON
      && !cb_s[1] |=> state == ST_IDLE)
      else $error("contact mode did not reset on open breaker");
   a_both_hold: assert property (s_run_quiet and supervision_mode_sel == MODE_BOTH
      && (cur_flt || cb_s[1]) |=> state == ST_RUN)
      else $error("combined mode reset while a criterion faulted");
   a_fire_trip: assert property (fire |=> BACKUP_TRIP ##1 (BACKUP_TRIP || $past(inhibit)))
      else $error("expiry did not raise backup trip");
   a_min_pulse: assert property ($fell(BACKUP_TRIP) && !$past(inhibit)
      |-> $past(on_cyc) >= 32'(trip_pulse_min_ms) * 32'(CYC_PER_MS))
      else $error("backup trip shorter than pulse length");
   a_rep_trip: assert property (s_launch and rep_en |=> REPEAT_TRIP)
      else $error("repeat trip missing");
   a_inhibit_off: assert property (inhibit |=> !BACKUP_TRIP && !REPEAT_TRIP
      && state == ST_IDLE)
      else $error("trip while off or blocked");
   a_tmr_clear: assert property (inhibit |=> tmr == 10'h000)
      else $error("timer kept while inhibited");
   a_cur_clear: assert property ((I_PH_A <= phase_current_threshold)
      && (I_PH_B <= phase_current_threshold) && (I_PH_C <= phase_current_threshold)
      && (I_RES <= residual_current_threshold) |=> !cur_flt)
      else $error("current criterion did not clear");
endmodule : bfbt_top
`default_nettype wire

// file: core/bfbt_pkg.sv
// Shared constants for the breaker failure backup trip block.
// Assumes a 100 MHz clock and a 32-bit AHB-Lite register bus.
package bfbt_pkg;
   // ----------------------------------------------------------
   // Timing
   // ----------------------------------------------------------
   localparam int CLK_PERIOD_NS  = 10;                      // Clock period
   localparam int MS_NS          = 1000000;                 // One millisecond
   localparam int MS_CYCLES      = MS_NS / CLK_PERIOD_NS;   // Cycles per ms
   localparam int CURR_RESET_MS  = 20;                      // Current reset time
   // ----------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------
   localparam logic [7:0] OFS_CTRL    = 8'h00;  // Mode, repeat enable
   localparam logic [7:0] OFS_DELAY   = 8'h04;  // Backup delay, ms
   localparam logic [7:0] OFS_PULSE   = 8'h08;  // Minimum trip pulse, ms
   localparam logic [7:0] OFS_PH_THR  = 8'h0C;  // Phase current threshold
   localparam logic [7:0] OFS_RES_THR = 8'h10;  // Residual threshold
   localparam logic [7:0] OFS_STATUS  = 8'h14;  // Sticky events, W1C
   localparam logic [7:0] OFS_MASK    = 8'h18;  // Interrupt mask
   localparam logic [7:0] OFS_STATE   = 8'h1C;  // Live state, read only
   // ----------------------------------------------------------
   // Fields and reset values
   // ----------------------------------------------------------
   localparam int CTRL_REP_BIT = 2;             // Repeat trip enable
   localparam int EV_BACKUP    = 0;             // Backup trip issued
   localparam int EV_REPEAT    = 1;             // Repeat trip issued
   localparam int EV_START     = 2;             // Timer launched
   localparam int EV_HEALTHY   = 3;             // Returned healthy
   localparam int EV_W         = 4;             // Event count
   localparam logic [9:0]  RST_DELAY   = 10'h0C8;   // 200 ms
   localparam logic [15:0] RST_PULSE   = 16'h0064;  // 100 ms
   localparam logic [15:0] RST_PH_THR  = 16'h001E;  // 30
   localparam logic [15:0] RST_RES_THR = 16'h0014;  // 20
   // Supervision modes, off after reset
   typedef enum logic [1:0] {MODE_OFF, MODE_CUR, MODE_CON, MODE_BOTH} bfbt_mode_t;
endpackage : bfbt_pkg

// file: core/bfbt_pulse_if.sv
// Interface between the trip sequencer and one pulse stretcher.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
`default_nettype none
interface bfbt_pulse_if;
   logic        load;    // Start a pulse
   logic        kill;    // End it at once
   logic        hold;    // Keep it while fault stays
   logic        tick;    // One millisecond strobe
   logic [15:0] len;     // Minimum length, ms
   logic        active;  // Pulse output
   modport ctl   (output load, kill, hold, tick, len, input active);
   modport pulse (input load, kill, hold, tick, len, output active);
endinterface : bfbt_pulse_if
`default_nettype wire

// file: core/bfbt_pulse.sv
// Minimum-width trip pulse stretcher counting millisecond ticks.
// Assumes tick is a one-cycle strobe from the same clock.
`timescale 1ns/10ps
`default_nettype none
module bfbt_pulse
(
   input  wire logic  CLOCK,
   input  wire logic  RESETN,
   bfbt_pulse_if.pulse p
);
   logic [15:0] cnt;       // Remaining ms
   logic        on;        // Pulse flop
   logic [15:0] next_cnt;
   logic        next_on;

   // Next pulse state; kill beats load
   always_comb
   begin
      next_cnt = cnt;
      next_on  = on;
      if (p.kill)
      begin
         next_cnt = 16'h0000;
         next_on  = 1'b0;
      end
      else if (p.load)
      begin
         next_cnt = p.len;
         next_on  = 1'b1;
      end
      else if (on && p.tick)
      begin
         if (cnt != 16'h0000)
            next_cnt = cnt - 16'h0001;
         else if (!p.hold)
            next_on = 1'b0;   // Length met and fault gone
      end
   end

   // Register
   always_ff @(posedge CLOCK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         cnt <= 16'h0000;
         on  <= 1'b0;
      end
      else
      begin
         cnt <= next_cnt;
         on  <= next_on;
      end
   end

   assign p.active = on;
endmodule : bfbt_pulse
`default_nettype wire

// file: testbench/bfbt_breaker_model.sv
// Behavioural circuit breaker: auxiliary contact and line currents.
// Assumes one clock; coil is any trip command aimed at this breaker.
`timescale 1ns/10ps
`default_nettype none
module bfbt_breaker_model
#(
   parameter int OPEN_CYC = 20      // Coil to contact open, cycles
)
(
   input  wire logic        clock,
   input  wire logic        resetn,
   input  wire logic        coil,
   input  wire logic        stuck,
   input  wire logic        reclose,
   input  wire logic [15:0] ph_level,
   input  wire logic [15:0] res_level,
   output logic             closed,
   output logic [15:0]      i_ph,
   output logic [15:0]      i_res
);
   int cnt;                         // Opening countdown
   // ----------------------------------------------------------
   // Contact: opens OPEN_CYC cycles after the coil, unless stuck
   // ----------------------------------------------------------
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         closed <= 1'b1;
         cnt    <= 0;
      end
      else if (reclose)
      begin
         closed <= 1'b1;
         cnt    <= 0;
      end
      else if (closed && coil && !stuck && cnt == 0)
         cnt <= OPEN_CYC;
      else if (cnt == 1)
      begin
         closed <= 1'b0;
         cnt    <= 0;
      end
      else if (cnt > 1)
         cnt <= cnt - 1;
   end
   // Current flows only while the main contacts are closed
   assign i_ph  = closed ? ph_level : 16'h0000;
   assign i_res = closed ? res_level : 16'h0000;
endmodule : bfbt_breaker_model
`default_nettype wire

// file: testbench/bfbt_top_test.sv
// Self-checking bench for the breaker failure backup trip block.
// Assumes the package, pulse interface, design and breaker model.
`timescale 1ns/10ps
`default_nettype none
module bfbt_top_test import bfbt_pkg::*;;
   localparam int CPM   = 10;      // Cycles per ms, shortened
   localparam int LIMIT = 30000;   // Watchdog ceiling, cycles
   // Case bits: mode[7:6] stuck ph res blk rep trip[0]
   typedef struct packed {
      bfbt_mode_t mode;
      logic stuck, ph, res, blk, rep, trip;
   } bfbt_case_t;
   localparam logic [7:0] CASES [10] = '{
      8'h30,   // Off, stuck, fault
      8'h50,   // Current, breaker opens
      8'h73,   // Current, stuck, repeat on
      8'h60,   // Current, stuck, no current
      8'h69,   // Current, stuck, residual only
      8'hA1,   // Contact, stuck, no current
      8'h90,   // Contact, breaker opens
      8'hE1,   // Both, stuck, no current
      8'hD0,   // Both, breaker opens
      8'h74};  // Current, stuck, blocked mid-run
   // ----------------------------------------------------------
   // Signals
   // ----------------------------------------------------------
   logic CLOCK, RESETN, HSEL, HWRITE, HREADYOUT, HRESP, BLOCK;
   logic [31:0] HADDR, HWDATA, HRDATA;
   logic [1:0]  HTRANS;
   logic        start, stuck, reclose, cb_closed, BACKUP_TRIP, REPEAT_TRIP, IRQ;
   logic [15:0] ph_lvl, res_lvl, i_ph, i_res;
   int          err_total, check_count, cycles;
   logic [31:0] rd;
   bfbt_case_t  c;
   wire         HREADY = HREADYOUT;   // Single slave
   // ----------------------------------------------------------
   // Design and breaker model
   // ----------------------------------------------------------
   bfbt_top #(.CYC_PER_MS(CPM)) bfbt_top_inst (.CLOCK(CLOCK), .RESETN(RESETN),
      .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
      .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADY), .HREADYOUT(HREADYOUT),
      .HRESP(HRESP), .HRDATA(HRDATA), .GENERAL_START_IN(start),
      .CB_CLOSED(cb_closed), .BLOCK(BLOCK), .I_PH_A(i_ph), .I_PH_B(i_ph),
      .I_PH_C(i_ph), .I_RES(i_res), .BACKUP_TRIP(BACKUP_TRIP),
      .REPEAT_TRIP(REPEAT_TRIP), .IRQ(IRQ));
   bfbt_breaker_model bfbt_breaker_model_inst (.clock(CLOCK), .resetn(RESETN),
      .coil(start | REPEAT_TRIP | BACKUP_TRIP), .stuck(stuck), .reclose(reclose),
      .ph_level(ph_lvl), .res_level(res_lvl), .closed(cb_closed), .i_ph(i_ph),
      .i_res(i_res));
   // Clock, 10 ns period
   initial
   begin
      CLOCK = 1'b0;
      forever #5 CLOCK = ~CLOCK;
   end
   // Watchdog against a hung wait
   always @(posedge CLOCK)
   begin
      cycles++;
      if (cycles == LIMIT)
      begin
         err_total++;
         summarize();
      end
   end
   // ----------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------
   // Counts and verdict, then ends the run
   task automatic summarize();
      $display("checks=%0d mismatches=%0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : summarize
   // One comparison
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
         err_total++;
      end
   endtask : chk
   // One single AHB-Lite word transfer
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      HSEL   <= 1'b1;
      HTRANS <= 2'h2;
      HADDR  <= {24'h000000, a};
      HWRITE <= w;
      do @(posedge CLOCK); while (HREADY !== 1'b1);
      HTRANS <= 2'h0;
      HSEL   <= 1'b0;
      HWDATA <= d;
      do @(posedge CLOCK); while (HREADY !== 1'b1);
      rd = HRDATA;
   endtask : bus
   // Wait whole milliseconds of the shortened time base
   task automatic wait_ms(input int n);
      repeat (n * CPM) @(posedge CLOCK);
   endtask : wait_ms
   // ----------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------
   localparam logic [7:0]  RA [7] = '{OFS_CTRL, OFS_DELAY, OFS_PULSE, OFS_PH_THR,
                                      OFS_RES_THR, OFS_MASK, 8'h20};
   localparam logic [31:0] RV [7] = '{32'h0, 32'hC8, 32'h64, 32'h1E, 32'h14, 32'h0, 32'h0};
   initial
   begin
      {RESETN, HSEL, HWRITE, BLOCK, start, stuck, reclose} = '0;
      {HADDR, HWDATA, HTRANS, ph_lvl, res_lvl} = '0;
      {err_total, check_count, cycles} = '0;
      repeat (5) @(posedge CLOCK);
      RESETN <= 1'b1;
      for (int i = 0; i < 7; i++)
      begin
         bus(1'b0, RA[i], 32'h0);
         chk(rd, RV[i]);
      end
      bus(1'b1, OFS_DELAY, 32'h3C);
      bus(1'b1, OFS_PULSE, 32'h0A);
      bus(1'b0, OFS_DELAY, 32'h0);
      chk(rd, 32'h3C);
      bus(1'b0, OFS_STATE, 32'h0);
      chk(rd, 32'h10);                     // Idle, breaker closed, no fault
      chk(HRESP, 1'b0);                    // Response always OKAY
      $display("register test done");
      for (int i = 0; i < 10; i++)
      begin
         c = bfbt_case_t'(CASES[i]);
         reclose <= 1'b1;
         stuck   <= c.stuck;
         ph_lvl  <= c.ph ? 16'h0064 : 16'h0000;
         res_lvl <= c.res ? 16'h0032 : 16'h0000;
         @(posedge CLOCK);
         reclose <= 1'b0;
         bus(1'b1, OFS_CTRL, {29'h0, c.rep, c.mode});
         wait_ms(2);
         start <= 1'b1;                    // Held high: one edge only
         wait_ms(1);
         chk(REPEAT_TRIP, c.rep);
         wait_ms(9);
         BLOCK <= c.blk;
         wait_ms(2);
         BLOCK <= 1'b0;
         wait_ms(46);
         chk(BACKUP_TRIP, 1'b0);
         wait_ms(6);
         chk(BACKUP_TRIP, c.trip);
         stuck <= 1'b0;
         wait_ms(5);
         chk(BACKUP_TRIP, c.trip);
         start <= 1'b0;
         wait_ms(7);
         chk({BACKUP_TRIP, REPEAT_TRIP}, 2'b00);
         $display("case %0d done", i);
      end
      bus(1'b0, OFS_STATUS, 32'h0);
      chk(rd & 32'h5, 32'h5);
      chk(IRQ, 1'b0);
      bus(1'b1, OFS_MASK, 32'h1);
      repeat (2) @(posedge CLOCK);
      chk(IRQ, 1'b1);
      bus(1'b1, OFS_STATUS, 32'hF);
      repeat (2) @(posedge CLOCK);
      chk(IRQ, 1'b0);
      bus(1'b0, OFS_STATUS, 32'h0);
      chk(rd, 32'h0);
      $display("interrupt test done");
      summarize();
   end
endmodule : bfbt_top_test
`default_nettype wire
